// file: hw/yvc_capture.v
// ycbcr 4:2:2 capture front end with apb registers and packed word output
// assumes pixel clock, data and syncs come from outside and are resynchronised
`timescale 1ns/1ps
`include "yvc_consts.vh"
module yvc_capture
(
  input  wire        i_clk,
  input  wire        i_reset_n,
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [11:0] i_paddr,
  input  wire [31:0] i_pwdata,
  output wire        o_pready,
  output reg  [31:0] o_prdata,
  output wire        o_pslverr,
  input  wire        i_pclk,
  input  wire [7:0]  i_luma,
  input  wire [7:0]  i_chroma,
  input  wire        i_hsync,
  input  wire        i_vsync,
  input  wire        i_field,
  output reg         o_hsync,
  output reg         o_hsync_oe_n,
  output reg         o_vsync,
  output reg         o_vsync_oe_n,
  output reg  [31:0] o_word,
  output reg         o_word_valid,
  output reg         o_field,
  output reg         o_vblank
);

  // computes the protection nibble for a set of flags
  function [3:0] yvc_prot;
    input f;
    input v;
    input h;
    begin
      yvc_prot = {v ^ h, f ^ h, f ^ v, f ^ v ^ h};
    end
  endfunction

  reg  [2:0]  sync_if;
  reg  [3:0]  cfg;
  reg  [8:0]  mode;
  reg  [15:0] h_start;
  reg  [15:0] h_len;
  reg  [15:0] hs_width;
  reg  [15:0] ppl;
  reg  [15:0] vs_width;
  reg  [15:0] lpf;
  reg  [7:0]  ecc_errs;

  // apb slave, zero wait states
  wire wr_en = i_psel & i_penable & i_pwrite;
  assign o_pready  = 1'b1;
  assign o_pslverr = 1'b0;

  always @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      sync_if  <= 3'h0;
      cfg      <= 4'h0;
      mode     <= 9'h000;
      h_start  <= 16'h0000;
      h_len    <= 16'h0000;
      hs_width <= 16'h0000;
      ppl      <= 16'h0000;
      vs_width <= 16'h0000;
      lpf      <= 16'h0000;
    end
    else if (wr_en)
    begin
      case (i_paddr)
        `YVC_OFF_SYNC_IF: sync_if <= i_pwdata[2:0];
        `YVC_OFF_CFG:     cfg <= i_pwdata[3:0];
        // field input wins over write enable mode
        `YVC_OFF_MODE:    mode <= {i_pwdata[8:6], i_pwdata[5] & ~i_pwdata[7], i_pwdata[4:0]};
        `YVC_OFF_HWIN:    {h_len, h_start} <= i_pwdata;
        `YVC_OFF_HGEN:    {ppl, hs_width} <= i_pwdata;
        `YVC_OFF_VGEN:    {lpf, vs_width} <= i_pwdata;
        default:          ;
      endcase
    end
  end

  // read mux; unmapped reads zero
  always @*
  begin
    case (i_paddr)
      `YVC_OFF_SYNC_IF: o_prdata = {29'h0, sync_if};
      `YVC_OFF_CFG:     o_prdata = {28'h0, cfg};
      `YVC_OFF_MODE:    o_prdata = {23'h0, mode};
      `YVC_OFF_HWIN:    o_prdata = {h_len, h_start};
      `YVC_OFF_HGEN:    o_prdata = {ppl, hs_width};
      `YVC_OFF_VGEN:    o_prdata = {lpf, vs_width};
      `YVC_OFF_STATUS:  o_prdata = {22'h0, ecc_errs, o_vblank, o_field};
      `YVC_OFF_DATA:    o_prdata = o_word;
      default:          o_prdata = 32'h0000_0000;
    endcase
  end

  // two-stage synchronisers for every pin input
  reg [19:0] pin_s1;
  reg [19:0] pin_s2;
  reg        pclk_d;
  always @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      pin_s1 <= 20'h00000;
      pin_s2 <= 20'h00000;
      pclk_d <= 1'b0;
    end
    else
    begin
      pin_s1 <= {i_pclk, i_luma, i_chroma, i_hsync, i_vsync, i_field};
      pin_s2 <= pin_s1;
      pclk_d <= pin_s2[19];
    end
  end

  wire        pix_tick = pin_s2[19] & ~pclk_d;  // rising pixel clock edge
  wire        emb_on   = sync_if[`YVC_SI_ENABLE];
  wire [7:0]  luma_in  = mode[`YVC_MD_DATA_POLARITY_INVERT] ? ~pin_s2[18:11] : pin_s2[18:11];
  wire [7:0]  chro_in  = mode[`YVC_MD_DATA_POLARITY_INVERT] ? ~pin_s2[10:3]  : pin_s2[10:3];
  // 8-bit streams: chroma lines unless bus swapped in generic mode
  wire [7:0]  sel8     = (cfg[`YVC_CF_SWAP] & ~emb_on) ? luma_in : chro_in;
  // 10-bit embedded sample, top eight bits used for codes
  wire [9:0]  s10      = {chro_in, luma_in[1:0]};
  wire [7:0]  code_b   = (emb_on & cfg[`YVC_CF_WIDTH10]) ? s10[9:2] : sel8;
  wire [7:0]  lum16    = cfg[`YVC_CF_SWAP] ? chro_in : luma_in;
  wire [7:0]  chr16    = cfg[`YVC_CF_SWAP] ? luma_in : chro_in;

  // timing code detector state
  reg  [1:0]  pre_cnt;
  reg         in_active;
  reg  [15:0] hpos;
  reg  [15:0] vcnt;
  reg  [1:0]  smp_idx;
  reg  [31:0] acc;
  reg         fld_latched;
  reg         vs_prev;
  reg         hs_prev;

  wire        st_f = code_b[6];
  wire        st_v = code_b[5];
  wire        st_h = code_b[4];
  wire [3:0]  st_p = code_b[3:0];
  wire        st_ok = yvc_prot(st_f, st_v, st_h) == st_p;

  // single-bit correction: pick the flag set whose code matches or is one bit off
  reg  [2:0]  fix_fvh;
  reg         fix_hit;
  integer     k;
  always @*
  begin
    fix_fvh = {st_f, st_v, st_h};
    fix_hit = 1'b0;
    for (k = 0; k < 8; k = k + 1)
    begin
      if (!fix_hit && ((({k[2:0], yvc_prot(k[2], k[1], k[0])} ^ code_b[6:0]) == 7'h00)
          || (^({k[2:0], yvc_prot(k[2], k[1], k[0])} ^ code_b[6:0]) &&
              ((({k[2:0], yvc_prot(k[2], k[1], k[0])} ^ code_b[6:0]) &
               (({k[2:0], yvc_prot(k[2], k[1], k[0])} ^ code_b[6:0]) - 7'h01)) == 7'h00))))
      begin
        fix_fvh = k[2:0];
        fix_hit = 1'b1;
      end
    end
  end

  // flags as used: corrected when enabled, else raw
  wire [2:0] use_fvh = sync_if[`YVC_SI_ECC] ? fix_fvh : {st_f, st_v, st_h};
  wire       code_now = (pre_cnt == 2'd3) & code_b[7];

  // discrete sync levels: pins after polarity, or internal counters without polarity when generating
  wire vs_lvl = mode[`YVC_MD_SYNCOUT] ? (vcnt < vs_width) :
                (pin_s2[1] ^ mode[`YVC_MD_VPOL]);
  wire hs_lvl = mode[`YVC_MD_SYNCOUT] ? (hpos < hs_width) :
                (pin_s2[2] ^ mode[`YVC_MD_HPOL]);
  wire fld_in = pin_s2[0] ^ mode[`YVC_MD_FPOL];

  // capture window and sample index relative to the line start
  wire in_win  = (hpos >= h_start) && (hpos < h_start + h_len);
  wire samp_ok = emb_on ? in_active & in_win : in_win;

  always @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      pre_cnt      <= 2'd0;
      in_active    <= 1'b0;
      hpos         <= 16'h0000;
      vcnt         <= 16'h0000;
      smp_idx      <= 2'd0;
      acc          <= 32'h0000_0000;
      o_word       <= 32'h0000_0000;
      o_word_valid <= 1'b0;
      o_field      <= 1'b0;
      o_vblank     <= 1'b0;
      fld_latched  <= 1'b0;
      vs_prev      <= 1'b0;
      hs_prev      <= 1'b0;
      ecc_errs     <= 8'h00;
    end
    else
    begin
      o_word_valid <= 1'b0;
      if (pix_tick)
      begin
        vs_prev <= vs_lvl;
        hs_prev <= hs_lvl;
        // preamble tracking
        if (code_now || !emb_on)
          pre_cnt <= 2'd0;
        else if (pre_cnt == 2'd0)
          pre_cnt <= (code_b == `YVC_PREAMBLE0) ? 2'd1 : 2'd0;
        else if (pre_cnt != 2'd3)
          pre_cnt <= (code_b == `YVC_PREAMBLE1) ? pre_cnt + 2'd1 :
                     ((code_b == `YVC_PREAMBLE0) ? 2'd1 : 2'd0);
        if (emb_on && code_now)
        begin
          if (!st_ok && ecc_errs != 8'hFF)
            ecc_errs <= ecc_errs + 8'h01;
          o_field  <= use_fvh[2];
          o_vblank <= use_fvh[1];
          in_active <= ~use_fvh[0] & ~use_fvh[1];
          hpos     <= 16'h0000;
          smp_idx  <= 2'd0;
        end
        else if (!emb_on && hs_lvl && !hs_prev)
        begin
          // new line from discrete sync
          hpos    <= 16'h0000;
          smp_idx <= 2'd0;
          vcnt    <= (vs_lvl && !vs_prev) || (vcnt + 16'h0001 >= lpf) ?
                     16'h0000 : vcnt + 16'h0001;
          o_vblank <= vs_lvl;
          if (mode[`YVC_MD_FIELD])
            o_field <= mode[`YVC_MD_FLATCH] ? fld_latched : fld_in;
        end
        else
        begin
          hpos <= (mode[`YVC_MD_SYNCOUT] && hpos + 16'h0001 >= ppl) ?
                  16'h0000 : hpos + 16'h0001;
          if (samp_ok && !(emb_on && pre_cnt != 2'd0) && code_b != `YVC_PREAMBLE0)
          begin
            // pack samples: 8-bit streams fill bytes low first
            if (emb_on || !mode[`YVC_MD_FMT16])
            begin
              case (smp_idx)
                2'd0: acc[7:0]   <= code_b;
                2'd1: acc[15:8]  <= code_b;
                2'd2: acc[23:16] <= code_b;
                default: acc[31:24] <= code_b;
              endcase
              smp_idx <= smp_idx + 2'd1;
              if (smp_idx == 2'd3)
              begin
                o_word_valid <= 1'b1;
                o_word <= pack({code_b, acc[23:0]});
              end
            end
            else
            begin
              // 16-bit: luma and chroma per pixel
              if (!smp_idx[0])
                acc[15:0] <= {lum16, chr16};
              smp_idx <= {1'b0, ~smp_idx[0]};
              if (smp_idx[0])
              begin
                o_word_valid <= 1'b1;
                o_word <= pack({lum16, chr16, acc[15:0]});
              end
            end
          end
        end
        if (vs_lvl && !vs_prev)
          fld_latched <= fld_in;
      end
    end
  end

  // byte order fix-up and 8-bit luma position before storage
  function [31:0] pack;
    input [31:0] w;
    reg   [31:0] t;
    begin
      // luma first on even position means swap within each pair
      t = (cfg[`YVC_CF_YPOS] && !emb_on && !mode[`YVC_MD_FMT16]) ?
          {w[23:16], w[31:24], w[7:0], w[15:8]} : w;
      pack = cfg[`YVC_CF_BSWAP] ? {t[7:0], t[15:8], t[23:16], t[31:24]} : t;
    end
  endfunction

  // sync outputs: driven when direction is output and embedded sync is off, polarity applied
  always @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_hsync      <= 1'b0;
      o_vsync      <= 1'b0;
      o_hsync_oe_n <= 1'b1;
      o_vsync_oe_n <= 1'b1;
    end
    else
    begin
      o_hsync_oe_n <= ~(mode[`YVC_MD_SYNCOUT] & ~emb_on);
      o_vsync_oe_n <= ~(mode[`YVC_MD_SYNCOUT] & ~emb_on);
      o_hsync      <= (hpos < hs_width) ^ mode[`YVC_MD_HPOL];
      o_vsync      <= (vcnt < vs_width) ^ mode[`YVC_MD_VPOL];
    end
  end

endmodule

// file: hw/yvc_consts.vh
// constants for the ycbcr video capture front end
// assumes inclusion by bare name from the single design file
`ifndef YVC_CONSTS_VH
`define YVC_CONSTS_VH
`define YVC_ADDR_W        12
`define YVC_OFF_SYNC_IF   12'h000
`define YVC_OFF_CFG       12'h004
`define YVC_OFF_MODE      12'h008
`define YVC_OFF_HWIN      12'h00C
`define YVC_OFF_HGEN      12'h010
`define YVC_OFF_VGEN      12'h014
`define YVC_OFF_STATUS    12'h018
`define YVC_OFF_DATA      12'h01C
// sync interface control bits
`define YVC_SI_ENABLE     0
`define YVC_SI_ECC        1
// capture config bits
`define YVC_CF_WIDTH10    0
`define YVC_CF_SWAP       1
`define YVC_CF_YPOS       2
`define YVC_CF_BSWAP      3
// mode setup bits
`define YVC_MD_DATA_POLARITY_INVERT       0
`define YVC_MD_FMT16      1
`define YVC_MD_SYNCOUT    2
`define YVC_MD_VPOL       3
`define YVC_MD_HPOL       4
`define YVC_MD_WEN        5
`define YVC_MD_FLATCH     6
`define YVC_MD_FIELD      7
`define YVC_MD_FPOL       8
`define YVC_PREAMBLE0     8'hFF
`define YVC_PREAMBLE1     8'h00
`endif

// file: testbench/yvc_capture_monitor.sv
// port checker for the capture block
// assumes binding onto yvc_capture, one clock domain
`timescale 1ns/1ps
module yvc_capture_monitor
(
  input wire        i_clk,
  input wire        i_reset_n,
  input wire        i_psel,
  input wire        i_penable,
  input wire        i_pwrite,
  input wire [11:0] i_paddr,
  input wire        o_pready,
  input wire [31:0] o_prdata,
  input wire        o_pslverr,
  input wire        o_hsync_oe_n,
  input wire        o_vsync_oe_n,
  input wire [31:0] o_word,
  input wire        o_word_valid,
  input wire        o_field,
  input wire        o_vblank
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);
  // read access in progress
  wire rd = i_psel && i_penable && !i_pwrite;
  // bus answers, word pacing, sync enables, readback
  property p_ready; i_psel && i_penable |-> o_pready; endproperty
  a_ready: assert property (p_ready) else $error("no ready");
  property p_okay; i_psel && i_penable |-> !o_pslverr; endproperty
  a_okay: assert property (p_okay) else $error("slave error");
  property p_pulse; o_word_valid |=> !o_word_valid [*8]; endproperty
  a_pulse: assert property (p_pulse) else $error("word too soon");
  property p_hold; $changed(o_word) |-> o_word_valid; endproperty
  a_hold: assert property (p_hold) else $error("word moved");
  property p_oe; o_hsync_oe_n == o_vsync_oe_n; endproperty
  a_oe: assert property (p_oe) else $error("enables differ");
  property p_stat; rd && i_paddr == 12'h018 |-> o_prdata[1:0] == {o_vblank, o_field}; endproperty
  a_stat: assert property (p_stat) else $error("bad status");
  property p_last; rd && i_paddr == 12'h01C |-> o_prdata == o_word; endproperty
  a_last: assert property (p_last) else $error("bad last word");
  property p_unmap; rd && i_paddr >= 12'h020 |-> o_prdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  // main scenarios reached
  c_word: cover property (o_word_valid);
  c_blank: cover property ($rose(o_vblank));
  c_drive: cover property (!o_hsync_oe_n);
endmodule
bind yvc_capture yvc_capture_monitor yvc_capture_monitor_inst
(
  .i_clk, .i_reset_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .o_pready, .o_prdata,
  .o_pslverr, .o_hsync_oe_n, .o_vsync_oe_n, .o_word, .o_word_valid, .o_field, .o_vblank
);

// file: testbench/yvc_capture_tb_top.sv
// bench for the capture block: registers, embedded and generic capture
// assumes the source model on the pixel pins and the bound checker
`timescale 1ns/1ps
module yvc_capture_tb_top;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] rd;
  logic [31:0] got;
  logic        hit = 1'b0;
  int          mismatches = 0;
  int          check_count = 0;
  logic [7:0]  smp [4] = '{8'h11, 8'h22, 8'h33, 8'h44};
  logic [3:0]  cf [3] = '{4'h2, 4'h6, 4'hA};
  logic [31:0] ex [3] = '{32'h4433_2211, 32'h3344_1122, 32'h1122_3344};
  wire  [31:0] prdata, word;
  wire  [7:0]  luma, chroma;
  wire         pready, pclk, vld, fld, vb, hs_o, hs_oe_n, vs_o, vs_oe_n, s_hs, s_vs, s_fld;
  // sync pins: device drives when its enable is low
  wire         hs_pin = hs_oe_n ? s_hs : hs_o;
  wire         vs_pin = vs_oe_n ? s_vs : vs_o;
  always #20 clk = ~clk;
  yvc_capture yvc_capture_inst (.i_clk(clk), .i_reset_n(rst_n), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata),
    .o_pslverr(), .i_pclk(pclk), .i_luma(luma), .i_chroma(chroma), .i_hsync(hs_pin),
    .i_vsync(vs_pin), .i_field(s_fld), .o_hsync(hs_o), .o_hsync_oe_n(hs_oe_n), .o_vsync(vs_o),
    .o_vsync_oe_n(vs_oe_n), .o_word(word), .o_word_valid(vld), .o_field(fld), .o_vblank(vb));
  yvc_src yvc_src_inst (.o_pclk(pclk), .o_luma(luma), .o_chroma(chroma), .o_hsync(s_hs),
    .o_vsync(s_vs), .o_field(s_fld));
  // keep the first word after arming
  always @(posedge clk)
    if (vld && !hit)
    begin
      got <= word;
      hit <= 1'b1;
    end
  task chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // one apb transfer, held until ready is seen
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task wword(input logic [31:0] e);
    for (int k = 0; k < 200 && !hit; k++)
      @(posedge clk);
    chk({31'h0, hit}, 32'h1);
    chk(got, e);
  endtask
  task wflag(input logic [1:0] e);
    for (int k = 0; k < 100 && {vb, fld} !== e; k++)
      @(posedge clk);
    chk({30'h0, vb, fld}, {30'h0, e});
  endtask
  task t_regs;
    apb(1'b1, 12'h004, 32'h5);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h5);
    apb(1'b1, 12'h008, 32'hA0);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, 32'h80);
    apb(1'b0, 12'h040, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, 12'h008, 32'h0);
    apb(1'b1, 12'h004, 32'h0);
  endtask
  task t_embed;
    apb(1'b1, 12'h00C, 32'h0004_0000);
    apb(1'b1, 12'h000, 32'h1);
    @(posedge clk) hit <= 1'b0;
    yvc_src_inst.code(1'b0, 1'b0, 1'b0, 8'h00);
    for (int j = 0; j < 4; j++)
      yvc_src_inst.pix(8'h5A, smp[j], 1'b0);
    wword(32'h4433_2211);
    yvc_src_inst.code(1'b0, 1'b1, 1'b1, 8'h00);
    wflag(2'b10);
    yvc_src_inst.code(1'b1, 1'b1, 1'b1, 8'h00);
    wflag(2'b11);
    apb(1'b0, 12'h018, 32'h0);
    chk(rd, 32'h3);
    apb(1'b0, 12'h01C, 32'h0);
    chk(rd, 32'h4433_2211);
  endtask
  task t_ecc;
    apb(1'b1, 12'h000, 32'h3);
    yvc_src_inst.code(1'b0, 1'b1, 1'b1, 8'h00);
    wflag(2'b10);
    yvc_src_inst.code(1'b0, 1'b0, 1'b0, 8'h20);
    wflag(2'b00);
    apb(1'b1, 12'h000, 32'h1);
    yvc_src_inst.code(1'b0, 1'b0, 1'b0, 8'h20);
    wflag(2'b10);
    apb(1'b0, 12'h018, 32'h0);
    chk(rd, 32'hA);
  endtask
  task t_gen8;
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b1, 12'h008, 32'h1);
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b1, 12'h004, {28'h0, cf[i]});
      @(posedge clk) hit <= 1'b0;
      yvc_src_inst.pix(8'h00, 8'h00, 1'b1);
      for (int j = 0; j < 4; j++)
        yvc_src_inst.pix(~smp[j], 8'h5A, 1'b0);
      wword(ex[i]);
    end
  endtask
  task t_gen16;
    apb(1'b1, 12'h008, 32'h2);
    apb(1'b1, 12'h004, 32'h2);
    @(posedge clk) hit <= 1'b0;
    yvc_src_inst.pix(8'h00, 8'h00, 1'b1);
    yvc_src_inst.pix(smp[0], smp[1], 1'b0);
    yvc_src_inst.pix(smp[2], smp[3], 1'b0);
    wword(32'h4433_2211);
  endtask
  task t_sync;
    apb(1'b1, 12'h010, 32'h0014_0004);
    apb(1'b1, 12'h014, 32'h000A_0002);
    apb(1'b1, 12'h008, 32'h4);
    for (int k = 0; k < 20 && hs_oe_n !== 1'b0; k++)
      @(posedge clk);
    chk({31'h0, hs_oe_n}, 32'h0);
    chk({30'h0, hs_o, vs_o}, 32'h3);
    apb(1'b1, 12'h008, 32'h1C);
    repeat (2) @(posedge clk);
    chk({30'h0, hs_o, vs_o}, 32'h0);
    apb(1'b1, 12'h008, 32'h0);
    for (int k = 0; k < 20 && hs_oe_n !== 1'b1; k++)
      @(posedge clk);
    chk({31'h0, hs_oe_n}, 32'h1);
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // reset, then the scenarios in turn
  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    t_embed;
    t_ecc;
    t_gen8;
    t_gen16;
    t_sync;
    wrap_up;
  end
  // watchdog well past the expected run
  initial
  begin
    #400000;
    mismatches++;
    wrap_up;
  end
endmodule

// file: testbench/yvc_src.sv
// stand-in for an external video decoder on the pixel pins
// assumes the bench calls one task at a time
`timescale 1ns/1ps
module yvc_src
(
  output logic       o_pclk   = 1'b0,
  output logic [7:0] o_luma   = 8'h00,
  output logic [7:0] o_chroma = 8'h00,
  output logic       o_hsync  = 1'b0,
  output logic       o_vsync  = 1'b0,
  output logic       o_field  = 1'b0
);
  // one sample, clock stands low between calls
  task pix(input logic [7:0] y, input logic [7:0] c, input logic h);
    o_luma <= y;
    o_chroma <= c;
    o_hsync <= h;
    #160 o_pclk <= 1'b1;
    #160 o_pclk <= 1'b0;
  endtask
  // timing code on chroma lines, flip corrupts the status word
  task code(input logic f, input logic v, input logic h, input logic [7:0] flip);
    logic [7:0] xy;
    xy = {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h} ^ flip;
    pix(8'h00, 8'hFF, 1'b0);
    pix(8'h00, 8'h00, 1'b0);
    pix(8'h00, 8'h00, 1'b0);
    pix(8'h00, xy, 1'b0);
  endtask
endmodule
